//--- core/cvcir_defines.svh
// constants of the charger voltage, current and identity register bank
`ifndef CVCIR_DEFINES_SVH
`define CVCIR_DEFINES_SVH
`define CVCIR_ADDR_STATUS 8'h00
`define CVCIR_ADDR_VOLT 8'h02
`define CVCIR_ADDR_IDENT 8'h03
`define CVCIR_ADDR_CURR 8'h04
`define CVCIR_VOLT_RESET 8'h0a
`define CVCIR_CURR_RESET 8'h89
`define CVCIR_CMD_BIT 7
`define CVCIR_VOLT_BASE_MV 13'h0dac
`define CVCIR_VOLT_STEP_MV 13'h0014
`define CVCIR_CHG_BASE_TENTH_MV 13'h0176
`define CVCIR_CHG_STEP_TENTH_MV 13'h0044
`define CVCIR_TERM_BASE_TENTH_MV 13'h0022
`define CVCIR_TERM_STEP_TENTH_MV 13'h0022
`define CVCIR_READ_ZERO 8'h00
`endif

//--- core/cvcir_pkg.sv
// types of the charger voltage, current and identity register bank
`default_nettype none
package cvcir_pkg;
  typedef struct packed {
    logic [5:0] volt_code;
    logic host_pin_polarity;
    logic host_pin_gate;
  } cvcir_volt_t;
  typedef struct packed {
    logic reset_cmd;
    logic [2:0] charge_sense_code;
    logic spare;
    logic [2:0] term_code;
  } cvcir_curr_t;
  typedef struct packed {
    logic [2:0] maker_code;
    logic part_code_bit1;
    logic part_code_bit0;
    logic [2:0] silicon_rev;
  } cvcir_ident_t;
endpackage
`default_nettype wire

//--- core/cvcir_regs.sv
// register bank at 02 to 04 plus the pin level bit of the status byte
// Summary of operation
// R1: voltage bits 7..2 are a code; target is 3.5 V plus code times 20 mV.
// R2: voltage register resets to 0AH, giving 3.54 V, polarity one, gate zero.
// R3: voltage bit 1 picks the active level of the on-the-go pin.
// R4: voltage bit 0 gates the pin; pin ignored while it is zero.
// R5: identity at 03 is read-only: maker, part and revision fields.
// R6: part code low bit tells the auto-charge variant from the high-impedance one.
// R7: writing one to current bit 7 resets the charger; reads return one.
// R8: current bits 6..4 add 27.2/13.6/6.8 mV to a 37.4 mV offset.
// R9: current bits 2..0 add 13.6/6.8/3.4 mV to a 3.4 mV offset.
// R10: current register resets to 89H: charge code 000, termination code 001.
// R11: status bit 7 reads back the present on-the-go pin level.
// R12: current bit 3 is stored and read back with no effect, resets one.
// R13: fields change only when a whole data byte write to the address completes.
`timescale 1ns/1ps
`default_nettype none
`include "cvcir_defines.svh"
module cvcir_regs #(
  parameter logic [2:0] MAKER_CODE = 3'h5, // arbitrary value
  parameter logic PART_CODE_HI = 1'h0, // arbitrary value
  parameter logic AUTO_CHARGE_VARIANT = 1'h1,
  parameter logic [2:0] SILICON_REV = 3'h2 // arbitrary value
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic wr_byte_done,
  input wire logic rd_req,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] wr_data,
  input wire logic [6:0] status_low_bits,
  input wire logic on_the_go_control_pin,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic [5:0] volt_code,
  output logic [12:0] regulation_mv,
  output logic host_pin_polarity,
  output logic host_pin_gate,
  output logic host_pin_active,
  output logic timer_kick_pin_level,
  output logic [2:0] charge_sense_code,
  output logic [12:0] charge_sense_tenth_mv,
  output logic [2:0] term_code,
  output logic [12:0] term_sense_tenth_mv,
  output logic charger_reset_pulse
);
  cvcir_pkg::cvcir_volt_t volt_q, volt_d;
  cvcir_pkg::cvcir_curr_t curr_q, curr_d;
  cvcir_pkg::cvcir_ident_t ident;
  logic sync1_q, sync2_q, sync3_q, level_q, level_d;
  logic [7:0] rd_data_q, rd_data_d;
  logic rd_valid_q, rd_valid_d, rst_pulse_q, rst_pulse_d, active_q, active_d;
  logic [12:0] reg_mv_q, reg_mv_d, chg_q, chg_d, term_q, term_d;

  // offset plus step times code, shared by the three set-point outputs
  function automatic logic [12:0] lin(input logic [12:0] base, input logic [12:0] step,
                                      input logic [5:0] code);
    lin = 13'(base + step * {7'h00, code});
  endfunction

  // constant fields, so writes can never alter them
  assign ident.maker_code = MAKER_CODE; // R5
  assign ident.part_code_bit1 = PART_CODE_HI; // R5
  assign ident.part_code_bit0 = AUTO_CHARGE_VARIANT; // R6
  assign ident.silicon_rev = SILICON_REV; // R5

  always_comb begin
    volt_d = volt_q;
    curr_d = curr_q;
    rst_pulse_d = 1'b0;
    if (wr_byte_done && reg_addr == `CVCIR_ADDR_VOLT) begin
      volt_d = cvcir_pkg::cvcir_volt_t'(wr_data); // R13 R1 R3 R4
    end
    if (wr_byte_done && reg_addr == `CVCIR_ADDR_CURR) begin
      curr_d = cvcir_pkg::cvcir_curr_t'(wr_data); // R13 R8 R9 R12
      curr_d.reset_cmd = 1'b1; // R7
      rst_pulse_d = wr_data[`CVCIR_CMD_BIT]; // R7
    end
  end

  // pin level only moves once the two late stages agree, filtering a one-cycle glitch
  always_comb begin
    level_d = level_q;
    if (sync2_q == sync3_q) begin
      level_d = sync3_q; // R11
    end
    // pin ignored unless gated on; match against the chosen active level
    active_d = volt_q.host_pin_gate && (level_q == volt_q.host_pin_polarity); // R3 R4
    reg_mv_d = lin(`CVCIR_VOLT_BASE_MV, `CVCIR_VOLT_STEP_MV, volt_q.volt_code); // R1
    chg_d = lin(`CVCIR_CHG_BASE_TENTH_MV, `CVCIR_CHG_STEP_TENTH_MV,
                {3'h0, curr_q.charge_sense_code}); // R8
    term_d = lin(`CVCIR_TERM_BASE_TENTH_MV, `CVCIR_TERM_STEP_TENTH_MV,
                 {3'h0, curr_q.term_code}); // R9
  end

  always_comb begin
    rd_valid_d = rd_req;
    rd_data_d = rd_data_q;
    if (rd_req) begin
      case (reg_addr)
        `CVCIR_ADDR_STATUS: rd_data_d = {level_q, status_low_bits}; // R11
        `CVCIR_ADDR_VOLT: rd_data_d = volt_q;
        `CVCIR_ADDR_IDENT: rd_data_d = ident; // R5
        `CVCIR_ADDR_CURR: rd_data_d = curr_q; // R7 R12
        default: rd_data_d = `CVCIR_READ_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      volt_q <= `CVCIR_VOLT_RESET; // R2
      curr_q <= `CVCIR_CURR_RESET; // R10
      rst_pulse_q <= 1'b0;
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      sync3_q <= 1'b0;
      level_q <= 1'b0;
      active_q <= 1'b0;
      reg_mv_q <= `CVCIR_VOLT_BASE_MV;
      chg_q <= `CVCIR_CHG_BASE_TENTH_MV;
      term_q <= `CVCIR_TERM_BASE_TENTH_MV;
      rd_data_q <= `CVCIR_READ_ZERO;
      rd_valid_q <= 1'b0;
    end else begin
      volt_q <= volt_d;
      curr_q <= curr_d;
      rst_pulse_q <= rst_pulse_d;
      sync1_q <= on_the_go_control_pin;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      level_q <= level_d;
      active_q <= active_d;
      reg_mv_q <= reg_mv_d;
      chg_q <= chg_d;
      term_q <= term_d;
      rd_data_q <= rd_data_d;
      rd_valid_q <= rd_valid_d;
    end
  end

  assign rd_data = rd_data_q;
  assign rd_valid = rd_valid_q;
  assign volt_code = volt_q.volt_code;
  assign regulation_mv = reg_mv_q;
  assign host_pin_polarity = volt_q.host_pin_polarity;
  assign host_pin_gate = volt_q.host_pin_gate;
  assign host_pin_active = active_q;
  assign timer_kick_pin_level = level_q;
  assign charge_sense_code = curr_q.charge_sense_code;
  assign charge_sense_tenth_mv = chg_q;
  assign term_code = curr_q.term_code;
  assign term_sense_tenth_mv = term_q;
  assign charger_reset_pulse = rst_pulse_q;
endmodule
`default_nettype wire

//--- test/cvcir_regs_properties.sv
// port checker for the register bank
`timescale 1ns/1ps
`default_nettype none
module cvcir_props(input wire logic clk_sys, resetn, wr_byte_done, rd_req, rd_valid,
  host_pin_gate, host_pin_active, charger_reset_pulse,
  input wire logic [7:0] reg_addr, wr_data, rd_data,
  input wire logic [5:0] volt_code, input wire logic [12:0] regulation_mv);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  wire logic w2 = wr_byte_done && reg_addr == 8'h02;
  wire logic w4 = wr_byte_done && reg_addr == 8'h04;
  // the target lags the code by one cycle, so compare against the previous code
  sequence volt_set;
    volt_code == $past(wr_data[7:2]) ##1 regulation_mv == 13'h0dac + 13'h0014 * $past(volt_code);
  endsequence
  AST_RD_ANSWER: assert property (rd_req |=> rd_valid) else $error("no answer");
  AST_RD_QUIET: assert property (!rd_req |=> !rd_valid) else $error("stray valid");
  AST_VOLT: assert property (w2 |=> volt_set) else $error("bad volt");
  AST_IDENT: assert property (rd_req && reg_addr == 8'h03 |=> rd_data == 8'haa) else $error("bad id");
  AST_CMD_READ: assert property (rd_req && reg_addr == 8'h04 |=> rd_data[7]) else $error("bit low");
  AST_KICK: assert property (w4 && wr_data[7] |=> charger_reset_pulse) else $error("no kick");
  AST_NO_KICK: assert property (!(w4 && wr_data[7]) |=> !charger_reset_pulse) else $error("kick");
  AST_GATE: assert property (host_pin_active |-> $past(host_pin_gate)) else $error("ungated");
endmodule
bind cvcir_regs cvcir_props chk_u(.clk_sys, .resetn, .wr_byte_done, .rd_req, .rd_valid,
  .host_pin_gate, .host_pin_active, .charger_reset_pulse, .reg_addr, .wr_data, .rd_data,
  .volt_code, .regulation_mv);
`default_nettype wire

//--- test/cvcir_host.sv
// host model issuing whole-byte reads and writes
`timescale 1ns/1ps
`default_nettype none
module cvcir_host(input wire logic clk_sys, input wire logic [7:0] rd_data,
  output logic wr_byte_done, rd_req, output logic [7:0] reg_addr, wr_data);
  initial {wr_byte_done, rd_req, reg_addr, wr_data} = '0;
  // released lines show the inverse so stale values cannot pass
  task automatic xfer(input logic w, input logic [7:0] a, x, output logic [7:0] d);
    @(negedge clk_sys);
    {wr_byte_done, rd_req, reg_addr, wr_data} = {w, !w, a, x};
    @(negedge clk_sys);
    {wr_byte_done, rd_req, reg_addr, wr_data} = {2'b00, ~a, ~x};
    d = rd_data;
  endtask
endmodule
`default_nettype wire

//--- test/tb.sv
// self-checking bench for the register bank
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk_sys = 1'b0;
  logic resetn, wr_byte_done, rd_req, rd_valid, host_pin_polarity, host_pin_gate;
  logic host_pin_active, timer_kick_pin_level, charger_reset_pulse, on_the_go_control_pin;
  logic [7:0] reg_addr, wr_data, rd_data, d, v, c;
  logic [6:0] status_low_bits;
  logic [5:0] volt_code;
  logic [2:0] charge_sense_code, term_code;
  logic [12:0] regulation_mv, charge_sense_tenth_mv, term_sense_tenth_mv;
  integer err_total = 0, total_checks = 0, seed = 22, cyc = 0, kicks = 0, kicks_exp = 0;
  always #12.5 clk_sys = ~clk_sys;
  cvcir_host host_u(.clk_sys, .rd_data, .wr_byte_done, .rd_req, .reg_addr, .wr_data);
  cvcir_regs dut_u(.clk_sys, .resetn, .wr_byte_done, .rd_req, .reg_addr, .wr_data,
    .status_low_bits, .on_the_go_control_pin, .rd_data, .rd_valid, .volt_code, .regulation_mv,
    .host_pin_polarity, .host_pin_gate, .host_pin_active, .timer_kick_pin_level,
    .charge_sense_code, .charge_sense_tenth_mv, .term_code, .term_sense_tenth_mv,
    .charger_reset_pulse);
  task automatic chk(input string n, input logic [12:0] e, g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rc(input string n, input logic [7:0] a, e);
    host_u.xfer(1'b0, a, 8'h00, d);
    chk(n, e, d);
  endtask
  task final_report;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // a run needs about 225 cycles
  always @(posedge clk_sys) begin
    cyc = cyc + 1;
    if (charger_reset_pulse === 1'b1) kicks = kicks + 1;
    if (cyc == 3000) begin
      err_total++;
      final_report;
    end
  end
  initial begin
    {resetn, on_the_go_control_pin, status_low_bits} = '0;
    repeat (8) @(negedge clk_sys);
    resetn = 1'b1;
    rc("volt", 8'h02, 8'h0a);
    rc("curr", 8'h04, 8'h89);
    host_u.xfer(1'b1, 8'h03, 8'h00, d);
    rc("id", 8'h03, 8'haa);
    rc("none", 8'h05, 8'h00);
    repeat (20) begin
      v = 8'($random(seed));
      c = 8'($random(seed));
      {on_the_go_control_pin, status_low_bits} = 8'($random(seed));
      host_u.xfer(1'b1, 8'h02, v, d);
      host_u.xfer(1'b1, 8'h04, c, d);
      rc("volt", 8'h02, v);
      rc("curr", 8'h04, c | 8'h80);
      kicks_exp = kicks_exp + c[7];
      chk("vcode", v[7:2], volt_code);
      chk("pol", v[1], host_pin_polarity);
      chk("gate", v[0], host_pin_gate);
      chk("ccode", c[6:4], charge_sense_code);
      chk("tcode", c[2:0], term_code);
      chk("kick", on_the_go_control_pin, timer_kick_pin_level);
      chk("mv", 13'h0dac + 13'h0014 * v[7:2], regulation_mv);
      chk("chg", 13'h0176 + 13'h0044 * c[6:4], charge_sense_tenth_mv);
      chk("term", 13'h0022 + 13'h0022 * c[2:0], term_sense_tenth_mv);
      chk("act", v[0] && on_the_go_control_pin == v[1], host_pin_active);
      rc("stat", 8'h00, {on_the_go_control_pin, status_low_bits});
    end
    chk("kicks", kicks_exp, kicks);
    // second reset in mid-run must bring back the reset bytes
    resetn = 1'b0;
    repeat (2) @(negedge clk_sys);
    resetn = 1'b1;
    rc("volt", 8'h02, 8'h0a);
    rc("curr", 8'h04, 8'h89);
    final_report;
  end
endmodule
`default_nettype wire
